/* inc/timer_ext_defs.svh */
// Register offsets, field positions, reset values and timing constants of the external-clock timer
`ifndef TIMER_EXT_DEFS_SVH
`define TIMER_EXT_DEFS_SVH
// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define REG_IDX_W 10
`define REG_IDX_TIMER_COUNT 10'h001
`define REG_IDX_INT_CONTROL 10'h00b
`define REG_IDX_PRESCALE_CFG 10'h081
`define REG_IDX_PORT_A_DIR 10'h085
`define REG_IDX_IRQ_STATUS 10'h090
`define REG_IDX_IRQ_MASK 10'h091
// ----------------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------------
`define RST_TIMER_COUNT 8'h00
`define RST_INT_CONTROL 8'h00
`define RST_PRESCALE_CFG 8'hff
`define RST_PORT_A_DIR 8'h1f
`define RST_IRQ 2'h0
`define PORT_A_DIR_MASK 8'h1f
`define INTC_IRQ_EN_BIT 5
`define INTC_FLAG_BIT 2
`define TIMER_COUNT_MAX 8'hff
// ----------------------------------------------------------------------------
// Phase clock timing
// ----------------------------------------------------------------------------
`define PHASE_SECOND 2'h1
`define PHASE_FOURTH 2'h3
`define PHASE_STEP 2'h1
`endif

/* inc/timer_ext_pkg.sv */
// Types shared by the external-clock timer
package timer_ext_pkg;
  // --------------------------------------------------------------------------
  // Timer configuration register layout
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic pullup_off;
    logic int_edge;
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_ratio;
  } prescale_cfg_t;
  // --------------------------------------------------------------------------
  // Interrupt status and mask layout
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic watchdog_event;
    logic overflow;
  } irq_bits_t;
  // --------------------------------------------------------------------------
  // APB answer bundle
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } apb_answer_t;
endpackage : timer_ext_pkg

/* logic/timer_ext_clock_prescaler.sv */
// Eight-bit timer/counter with external clock, shared prescaler and APB registers
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "timer_ext_defs.svh"

module timer_ext_clock_prescaler #(
  parameter int ADDR_W = 12,
  parameter int PRESCALE_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire logic timer_ext_clock_pin,
  input wire logic watchdog_tick_pin,
  // Watchdog side
  input wire logic watchdog_clear_op,
  output logic watchdog_clear,
  output logic watchdog_timeout,
  // Interrupt
  output logic irq
);
  import timer_ext_pkg::*;

  // --------------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------------
  generate
    if (PRESCALE_W != 8 || ADDR_W < `REG_IDX_W + 2)
    begin : bad_params
      $error("Prescaler must be 8 bits and address wide enough for the map");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic ext_meta;
  logic ext_sync;
  logic wdt_meta;
  logic wdt_sync;
  logic src_prev;
  logic next_src_prev;
  logic wdt_prev;
  logic next_wdt_prev;
  logic [PRESCALE_W-1:0] psc;
  logic [PRESCALE_W-1:0] next_psc;
  logic samp;
  logic next_samp;
  logic samp_prev;
  logic next_samp_prev;
  logic inc_pend;
  logic next_inc_pend;
  logic post_prev;
  logic next_post_prev;
  logic [7:0] timer_count;
  logic [7:0] next_timer_count;
  logic [7:0] int_control;
  logic [7:0] next_int_control;
  prescale_cfg_t cfg;
  prescale_cfg_t next_cfg;
  logic [7:0] port_a_direction;
  logic [7:0] next_port_a_direction;
  irq_bits_t irq_status;
  irq_bits_t next_irq_status;
  irq_bits_t irq_mask;
  irq_bits_t next_irq_mask;
  apb_answer_t answer;
  apb_answer_t next_answer;
  logic next_watchdog_clear;
  logic next_watchdog_timeout;
  logic next_irq;

  // --------------------------------------------------------------------------
  // Combinational helpers
  // --------------------------------------------------------------------------
  logic access;
  logic wr_en;
  logic [`REG_IDX_W-1:0] idx;
  logic hit;
  logic [7:0] rd_byte;
  logic to_timer;
  logic src_level;
  logic src_rise;
  logic wdt_rise;
  logic psc_clear;
  logic psc_count;
  logic timer_psc_out;
  logic post_out;
  logic timer_wr;
  logic ovf_event;
  irq_bits_t irq_clear;
  irq_bits_t irq_set;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      wdt_meta <= 1'b0;
      wdt_sync <= 1'b0;
    end
    else
    begin
      ext_meta <= timer_ext_clock_pin;
      ext_sync <= ext_meta;
      wdt_meta <= watchdog_tick_pin;
      wdt_sync <= wdt_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Phase clocks and prescaler path
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_phase = phase + `PHASE_STEP;
    to_timer = ~cfg.prescaler_assign;
    // Edge select by inversion, so a rising level always marks the counted edge
    if (cfg.clock_source_select)
    begin
      src_level = ext_sync ^ cfg.source_edge_select;
    end
    else
    begin
      src_level = phase[1];
    end
    src_rise = src_level & ~src_prev;
    wdt_rise = wdt_sync & ~wdt_prev;
    next_src_prev = src_level;
    next_wdt_prev = wdt_sync;
    // One counter, owned by either the timer or the watchdog
    psc_count = to_timer ? src_rise : wdt_rise;
    timer_wr = wr_en && idx == `REG_IDX_TIMER_COUNT;
    psc_clear = (to_timer & timer_wr) | (~to_timer & watchdog_clear_op);
    if (psc_clear)
    begin
      next_psc = '0;
    end
    else if (psc_count)
    begin
      next_psc = psc + 8'h01;
    end
    else
    begin
      next_psc = psc;
    end
    // Divided output bit is symmetrical; unassigned prescaler is bypassed
    if (to_timer)
    begin
      timer_psc_out = psc[cfg.prescale_ratio];
      post_out = wdt_sync;
    end
    else
    begin
      timer_psc_out = src_level;
      if (cfg.prescale_ratio == 3'h0)
      begin
        post_out = wdt_sync;
      end
      else
      begin
        post_out = psc[3'(cfg.prescale_ratio - 3'h1)];
      end
    end
    next_post_prev = post_out;
    next_watchdog_timeout = post_out & ~post_prev;
    next_watchdog_clear = watchdog_clear_op;
    // Synchroniser on the second and fourth phases
    if (phase == `PHASE_SECOND || phase == `PHASE_FOURTH)
    begin
      next_samp = timer_psc_out;
    end
    else
    begin
      next_samp = samp;
    end
    next_samp_prev = samp;
    next_inc_pend = samp & ~samp_prev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 2'h0;
      // Edge detectors start at the counted level of an idle low pin under the reset configuration
      src_prev <= 1'b1;
      wdt_prev <= 1'b0;
      psc <= '0;
      post_prev <= 1'b0;
      samp <= 1'b1;
      samp_prev <= 1'b1;
      inc_pend <= 1'b0;
      watchdog_timeout <= 1'b0;
      watchdog_clear <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      src_prev <= next_src_prev;
      wdt_prev <= next_wdt_prev;
      psc <= next_psc;
      post_prev <= next_post_prev;
      samp <= next_samp;
      samp_prev <= next_samp_prev;
      inc_pend <= next_inc_pend;
      watchdog_timeout <= next_watchdog_timeout;
      watchdog_clear <= next_watchdog_clear;
    end
  end

  // --------------------------------------------------------------------------
  // APB decode and read mux
  // --------------------------------------------------------------------------
  always_comb
  begin
    access = psel & penable;
    wr_en = access & answer.ready & pwrite;
    idx = paddr[`REG_IDX_W+1:2];
    hit = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      `REG_IDX_TIMER_COUNT: rd_byte = timer_count;
      `REG_IDX_INT_CONTROL:
      begin
        rd_byte = int_control;
        rd_byte[`INTC_FLAG_BIT] = irq_status.overflow;
      end
      `REG_IDX_PRESCALE_CFG: rd_byte = cfg;
      `REG_IDX_PORT_A_DIR: rd_byte = port_a_direction;
      `REG_IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status};
      `REG_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask};
      default: hit = 1'b0;
    endcase
    next_answer.ready = access & ~answer.ready;
    next_answer.slverr = access & ~answer.ready & ~hit;
    if (access && !answer.ready && !pwrite)
    begin
      next_answer.rdata = {24'h000000, rd_byte};
    end
    else
    begin
      next_answer.rdata = answer.rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Registers, timer count and interrupts
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_cfg = cfg;
    next_int_control = int_control;
    next_port_a_direction = port_a_direction;
    next_irq_mask = irq_mask;
    next_timer_count = timer_count;
    irq_clear = '0;
    ovf_event = 1'b0;
    if (timer_wr)
    begin
      next_timer_count = pwdata[7:0];
    end
    else if (inc_pend)
    begin
      next_timer_count = timer_count + 8'h01;
      ovf_event = timer_count == `TIMER_COUNT_MAX;
    end
    if (wr_en)
    begin
      case (idx)
        `REG_IDX_INT_CONTROL:
        begin
          next_int_control = pwdata[7:0];
          irq_clear.overflow = ~pwdata[`INTC_FLAG_BIT];
        end
        `REG_IDX_PRESCALE_CFG: next_cfg = prescale_cfg_t'(pwdata[7:0]);
        `REG_IDX_PORT_A_DIR: next_port_a_direction = pwdata[7:0] & `PORT_A_DIR_MASK;
        `REG_IDX_IRQ_STATUS: irq_clear = irq_bits_t'(pwdata[1:0]);
        `REG_IDX_IRQ_MASK: next_irq_mask = irq_bits_t'(pwdata[1:0]);
        default: next_cfg = cfg;
      endcase
    end
    irq_set.overflow = ovf_event;
    irq_set.watchdog_event = next_watchdog_timeout;
    // Setting wins over a clear in the same cycle
    next_irq_status = (irq_status & ~irq_clear) | irq_set;
    next_irq = |(irq_status & irq_mask & {1'b1, int_control[`INTC_IRQ_EN_BIT]});
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_count <= `RST_TIMER_COUNT;
      int_control <= `RST_INT_CONTROL;
      cfg <= `RST_PRESCALE_CFG;
      port_a_direction <= `RST_PORT_A_DIR;
      irq_status <= `RST_IRQ;
      irq_mask <= `RST_IRQ;
      answer <= '0;
      irq <= 1'b0;
    end
    else
    begin
      timer_count <= next_timer_count;
      int_control <= next_int_control;
      cfg <= next_cfg;
      port_a_direction <= next_port_a_direction;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      answer <= next_answer;
      irq <= next_irq;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign prdata = answer.rdata;
  assign pready = answer.ready;
  assign pslverr = answer.slverr;

endmodule : timer_ext_clock_prescaler
`default_nettype wire

/* verification/timer_ext_clock_prescaler_assertions.sv */
// Concurrent checks on the external-clock timer ports
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module timer_ext_checker #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Watchdog and interrupt
  input wire logic watchdog_clear_op,
  input wire logic watchdog_clear,
  input wire logic watchdog_timeout,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready missing after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_clear_follows: assert property (watchdog_clear_op |=> watchdog_clear)
    else $error("watchdog clear not passed on");
  a_clear_cause: assert property (watchdog_clear |-> $past(watchdog_clear_op))
    else $error("watchdog clear without request");
  a_timeout_pulse: assert property (watchdog_timeout |=> !watchdog_timeout)
    else $error("watchdog timeout longer than one cycle");
  c_refused: cover property (pready && pslverr);
  c_timeout: cover property (watchdog_timeout);
  c_irq: cover property ($rose(irq));
endmodule : timer_ext_checker
`default_nettype wire

/* verification/ext_clock_source.sv */
// External clock source model driving a clock pin with pulse trains
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Pulse train generator
// ----------------------------------------
module ext_clock_source #(
  parameter int HALF = 3
) (
  // Clock and control
  input wire logic pclk,
  input wire logic start,
  input wire logic idle_lvl,
  input wire logic [15:0] pulses,
  // Pin and status
  output logic pin,
  output logic busy
);
  logic [15:0] left = 16'h0;
  logic [3:0] cnt = 4'h0;
  logic act = 1'b0;
  // Pin stands at its idle level outside a train
  assign pin = idle_lvl ^ act;
  assign busy = start | (left != 16'h0);
  always @(posedge pclk)
  begin
    if (start)
    begin
      left <= pulses;
      cnt <= 4'h0;
    end
    else if (left != 16'h0)
    begin
      if (cnt == 4'(HALF))
      begin
        cnt <= 4'h0;
        act <= ~act;
        if (act)
          left <= left - 16'h1;
      end
      else
        cnt <= cnt + 4'h1;
    end
  end
endmodule : ext_clock_source
`default_nettype wire

/* verification/test_timer_ext_clock_prescaler.sv */
// Self-checking bench of the external-clock timer
`timescale 1ns/10ps
`default_nettype none
`include "timer_ext_defs.svh"
module test_timer_ext_clock_prescaler;
  import timer_ext_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [9:0] cfg = `REG_IDX_PRESCALE_CFG;
  localparam logic [9:0] tc = `REG_IDX_TIMER_COUNT;
  localparam logic [9:0] sts = `REG_IDX_IRQ_STATUS;
  localparam logic [9:0] msk = `REG_IDX_IRQ_MASK;
  localparam logic [9:0] rst_idx[5] = '{cfg, tc, `REG_IDX_PORT_A_DIR, `REG_IDX_INT_CONTROL, sts};
  localparam logic [31:0] rst_val[5] = '{32'hff, 32'h0, 32'h1f, 32'h0, 32'h0};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, a;
  logic pready, pslverr, er, wdc_op = 1'b0, wdc, wdt, irq, tpin, wpin, bt, bw;
  logic go_t = 1'b0, go_w = 1'b0, idle_t = 1'b0;
  logic [15:0] pul = 16'h0;
  int error_cnt = 0, checks = 0, wto = 0, r, n, d;
  always #20 pclk = ~pclk;
  always @(posedge pclk)
    if (wdt === 1'b1)
      wto <= wto + 1;
  timer_ext_clock_prescaler timer_ext_clock_prescaler_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_ext_clock_pin(tpin), .watchdog_tick_pin(wpin), .watchdog_clear_op(wdc_op),
    .watchdog_clear(wdc), .watchdog_timeout(wdt), .irq(irq));
  ext_clock_source ext_clock_source_inst (.pclk(pclk), .start(go_t), .idle_lvl(idle_t), .pulses(pul),
    .pin(tpin), .busy(bt));
  ext_clock_source ext_clock_source_wd_inst (.pclk(pclk), .start(go_w), .idle_lvl(1'b0), .pulses(pul),
    .pin(wpin), .busy(bw));
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  function automatic int tdiv(input int q);
    return 1 << (q + 1);
  endfunction : tdiv
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_n(input int c);
    repeat (c) @(posedge pclk);
  endtask : wait_n
  task automatic wdclr;
    wdc_op <= 1'b1;
    @(posedge pclk);
    wdc_op <= 1'b0;
    wait_n(4);
  endtask : wdclr
  task automatic run(input logic w, input int k);
    pul <= 16'(k);
    if (w)
      go_w <= 1'b1;
    else
      go_t <= 1'b1;
    @(posedge pclk);
    go_w <= 1'b0;
    go_t <= 1'b0;
    do
      @(posedge pclk);
    while (bt | bw);
    wait_n(16);
  endtask : run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    wait_n(80000);
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'hf8caad24));
    wait_n(4);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rst_idx[i])
    begin
      apb(1'b0, rst_idx[i], 32'h0);
      chk(rd, rst_val[i]);
    end
    apb(1'b1, `REG_IDX_PORT_A_DIR, 32'hff);
    apb(1'b0, `REG_IDX_PORT_A_DIR, 32'h0);
    chk(rd, 32'h1f);
    apb(1'b0, 10'h3ff, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    for (r = 0; r < 9; r++)
    begin
      d = (r == 8) ? 1 : tdiv(r);
      apb(1'b1, cfg, (r == 8) ? 32'h08 : 32'(r));
      wait_n(16);
      apb(1'b0, tc, 32'h0);
      a = rd;
      wait_n(40 * d - 4);
      apb(1'b0, tc, 32'h0);
      chk({24'h0, rd[7:0] - a[7:0]}, 32'ha);
    end
    $display("test timer_ratio done");
    apb(1'b1, cfg, 32'h08);
    apb(1'b1, msk, 32'h1);
    apb(1'b1, `REG_IDX_INT_CONTROL, 32'h20);
    apb(1'b1, sts, 32'h3);
    apb(1'b1, tc, 32'hfe);
    wait_n(20);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `REG_IDX_INT_CONTROL, 32'h0);
    chk(rd, 32'h24);
    apb(1'b1, msk, 32'h0);
    wait_n(2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, msk, 32'h1);
    apb(1'b1, sts, 32'h1);
    wait_n(2);
    chk({31'h0, irq}, 32'h0);
    $display("test overflow done");
    r = $urandom % 8;
    n = 1 + $urandom % 4;
    wdclr();
    apb(1'b1, tc, 32'h0);
    apb(1'b1, cfg, 32'h2f);
    wdclr();
    apb(1'b1, cfg, 32'h08 | 32'(r));
    wdclr();
    a = wto;
    run(1'b1, (1 << r) * n);
    chk(wto - a, 32'(n));
    $display("test watchdog done");
    for (int j = 0; j < 2; j++)
    begin
      r = j ? $urandom % 8 : 8;
      n = 1 + $urandom % 4;
      d = (r == 8) ? 1 : tdiv(r);
      wdclr();
      apb(1'b1, cfg, (r == 8) ? 32'h28 : 32'h20 | 32'(r));
      apb(1'b1, tc, 32'h0);
      run(1'b0, d * n);
      apb(1'b0, tc, 32'h0);
      chk({24'h0, rd[7:0]}, 32'(n));
    end
    apb(1'b1, cfg, 32'h38);
    wait_n(16);
    apb(1'b1, tc, 32'h0);
    idle_t <= 1'b1;
    wait_n(16);
    apb(1'b0, tc, 32'h0);
    chk(rd, 32'h0);
    idle_t <= 1'b0;
    wait_n(16);
    apb(1'b0, tc, 32'h0);
    chk(rd, 32'h1);
    $display("test counter done");
    print_verdict();
  end
endmodule : test_timer_ext_clock_prescaler
bind timer_ext_clock_prescaler timer_ext_checker #(.ADDR_W(ADDR_W)) timer_ext_checker_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .watchdog_clear_op(watchdog_clear_op), .watchdog_clear(watchdog_clear),
  .watchdog_timeout(watchdog_timeout), .irq(irq));
`default_nettype wire
